/* rtl/prx_pkg.sv */
// Register map, field positions and drive tables for the proximity readout block
package prx_pkg;
    localparam logic [7:0] PRX_ADDR_SETUP  = 8'h0f;
    localparam logic [7:0] PRX_ADDR_IDENT  = 8'h12;
    localparam logic [7:0] PRX_ADDR_FLAGS  = 8'h13;
    localparam logic [7:0] PRX_ADDR_RES_LO = 8'h18;
    localparam logic [7:0] PRX_ADDR_RES_HI = 8'h19;
    localparam logic [7:0] PRX_ADDR_TRIM   = 8'h1e;

    localparam logic [7:0] PRX_SETUP_RST   = 8'h00;
    localparam logic [7:0] PRX_TRIM_RST    = 8'h00;
    localparam logic [7:0] PRX_FLAGS_RST   = 8'h00;
    // Arbitrary neutral identity value
    localparam logic [7:0] PRX_IDENT_DFLT  = 8'h5a;

    localparam int PRX_DRIVE_MSB = 7;
    localparam int PRX_DRIVE_LSB = 6;
    localparam int PRX_DIODE_MSB = 5;
    localparam int PRX_DIODE_LSB = 4;
    localparam int PRX_GAIN_MSB  = 3;
    localparam int PRX_GAIN_LSB  = 2;
    localparam int PRX_SIGN_BIT  = 7;
    localparam int PRX_FLAG_SAT  = 6;
    localparam int PRX_FLAG_EVT  = 5;
    localparam int PRX_FLAG_RDY  = 1;

    localparam logic [1:0] PRX_DIODE_NONE  = 2'h0;
    localparam logic [1:0] PRX_DIODE_BROAD = 2'h1;
    localparam logic [1:0] PRX_DIODE_IR    = 2'h2;

    typedef enum logic [1:0]
    {
        PRX_LK_IDLE = 2'b01,
        PRX_LK_WAIT = 2'b10
    } prx_link_state_t;

    // Nominal LED sink current in tenths of a milliampere
    function automatic logic [10:0] prx_led_ma10(input logic [1:0] code, input logic reduce);
        logic [10:0] val;
        val = 11'h000;
        case ({reduce, code})
            3'h0:    val = 11'h4b0;
            3'h1:    val = 11'h258;
            3'h2:    val = 11'h12c;
            3'h3:    val = 11'h096;
            3'h4:    val = 11'h096;
            3'h5:    val = 11'h04b;
            3'h6:    val = 11'h026;
            default: val = 11'h013;
        endcase
        return val;
    endfunction
endpackage

/* rtl/prx_readout.sv */
// Proximity readout registers: analog setup, identity, flags, coherent result and offset trim
//
// Contract
// R1: LED sink current follows bits 7:6, 120 mA down to 15 mA normally.
// R2: Reduce input selects the reduced current column, about one eighth.
// R3: Bits 5:4 pick photodiode: 00 none, 01 broadband, 10 infrared.
// R4: Host never writes 11 into the photodiode field.
// R5: Bits 3:2 set amplifier gain 1x, 2x, 4x or 8x.
// R6: Read-only identity byte; writes leave it unchanged.
// R7: Flags register is read-only, resets to zero, shows internal state only.
// R8: Flag bits 7, 4:2 and 0 read as zero.
// R9: Flag bit 6 shows the last conversion saturated.
// R10: Flag bit 5 follows the pending proximity interrupt, masked or not.
// R11: Flag bit 1 sets once a cycle completes after enabling.
// R12: 16-bit result: low byte at 0x18, high byte at 0x19.
// R13: Reading low byte copies high byte to shadow; high read returns shadow.
// R14: Both result bytes returned come from the same cycle.
// R15: Host should read both bytes in one auto-increment transfer.
// R16: Trim bit 7 low shifts result down, high shifts it up.
// R17: Trim magnitude scales with gain, LED drive and pulse count.
// R18: Trim clears to zero at reset, no correction until written.
// R19: Host should tune the trim in a closed loop.
// R20: Measurement runs only while the function-enable input is set.
// R21: Interrupt pin stays idle while unmask is clear; flag still shows.
// R22: Result and flags update at the end of each completed conversion.
`timescale 1ns/100ps
`default_nettype none
module prx_readout
    import prx_pkg::*;
#(
    parameter logic [7:0] IDENT_VALUE = PRX_IDENT_DFLT,
    parameter int          RESULT_W    = 16
)
(
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        bus_clk_in,
    input  wire logic        req_valid_in,
    input  wire logic        req_write_in,
    input  wire logic [7:0]  req_addr_in,
    input  wire logic [7:0]  req_wdata_in,
    output logic             req_ready_out,
    output logic             rsp_valid_out,
    output logic [7:0]       rsp_rdata_out,
    input  wire logic        prox_function_on_in,
    input  wire logic        prox_irq_unmask_in,
    input  wire logic        led_current_reduce_in,
    input  wire logic [7:0]  led_pulse_count_in,
    input  wire logic        conv_done_in,
    input  wire logic [15:0] conv_data_in,
    input  wire logic        conv_overload_in,
    input  wire logic        prox_irq_pending_in,
    output logic             prox_measure_run_out,
    output logic [1:0]       led_current_select_out,
    output logic             led_current_reduce_out,
    output logic [10:0]      led_current_ma10_out,
    output logic             broadband_diode_en_out,
    output logic             infrared_diode_en_out,
    output logic [3:0]       prox_amp_gain_out,
    output logic             irq_pin_out,
    output logic             irq_pin_oe_out
);
    if (RESULT_W != 16)
    begin : g_bad_width
        $error("prx_readout: result width must be 16");
    end

    // Link domain: request capture and response
    prx_link_state_t lk_state;
    logic            lk_req_tgl;
    logic            lk_write;
    logic [7:0]      lk_addr;
    logic [7:0]      lk_wdata;
    logic            lk_ack_s1;
    logic            lk_ack_s2;
    logic            lk_ack_s3;
    wire  logic      lk_ack_seen = lk_ack_s2 ^ lk_ack_s3;
    wire  logic      lk_take     = (lk_state == PRX_LK_IDLE) && req_valid_in;

    // Core domain
    logic            cr_req_s1;
    logic            cr_req_s2;
    logic            cr_req_s3;
    logic            cr_ack_tgl;
    logic [7:0]      cr_rdata;
    logic [7:0]      analog_setup;
    logic [7:0]      crosstalk_trim;
    logic [15:0]     prox_result;
    logic [7:0]      result_shadow;
    logic            prox_overload_flag;
    logic            prox_result_ready;
    wire  logic      cr_req_seen = cr_req_s2 ^ cr_req_s3;

    assign req_ready_out = (lk_state == PRX_LK_IDLE);

    always_ff @(posedge bus_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            lk_state      <= PRX_LK_IDLE;
            lk_req_tgl    <= 1'b0;
            lk_write      <= 1'b0;
            lk_addr       <= 8'h00;
            lk_wdata      <= 8'h00;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 8'h00;
        end
        else
        begin
            rsp_valid_out <= 1'b0;
            case (lk_state)
                PRX_LK_IDLE:
                begin
                    if (lk_take)
                    begin
                        // Held stable until the core acknowledges, so the word crosses safely
                        lk_write   <= req_write_in;
                        lk_addr    <= req_addr_in;
                        lk_wdata   <= req_wdata_in;
                        lk_req_tgl <= ~lk_req_tgl;
                        lk_state   <= PRX_LK_WAIT;
                    end
                end
                PRX_LK_WAIT:
                begin
                    if (lk_ack_seen)
                    begin
                        rsp_valid_out <= 1'b1;
                        rsp_rdata_out <= cr_rdata;
                        lk_state      <= PRX_LK_IDLE;
                    end
                end
                default:
                begin
                    lk_state <= PRX_LK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge bus_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            lk_ack_s1 <= 1'b0;
            lk_ack_s2 <= 1'b0;
            lk_ack_s3 <= 1'b0;
        end
        else
        begin
            lk_ack_s1 <= cr_ack_tgl;
            lk_ack_s2 <= lk_ack_s1;
            lk_ack_s3 <= lk_ack_s2;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cr_req_s1 <= 1'b0;
            cr_req_s2 <= 1'b0;
            cr_req_s3 <= 1'b0;
        end
        else
        begin
            cr_req_s1 <= lk_req_tgl;
            cr_req_s2 <= cr_req_s1;
            cr_req_s3 <= cr_req_s2;
        end
    end

    // Register decode
    wire logic hit_setup  = (lk_addr == PRX_ADDR_SETUP);
    wire logic hit_trim   = (lk_addr == PRX_ADDR_TRIM);
    wire logic hit_res_lo = (lk_addr == PRX_ADDR_RES_LO);
    wire logic cr_wr      = cr_req_seen && lk_write;
    wire logic cr_rd      = cr_req_seen && !lk_write;

    wire logic [7:0] flags_view = {1'b0, prox_overload_flag, prox_irq_pending_in,
                                   3'h0, prox_result_ready, 1'b0}; // R7 R8 R9 R10 R11

    logic [7:0] rd_mux;
    always_comb
    begin
        case (lk_addr)
            PRX_ADDR_SETUP:  rd_mux = analog_setup;
            PRX_ADDR_IDENT:  rd_mux = IDENT_VALUE; // R6
            PRX_ADDR_FLAGS:  rd_mux = flags_view;
            PRX_ADDR_RES_LO: rd_mux = prox_result[7:0]; // R12
            PRX_ADDR_RES_HI: rd_mux = result_shadow; // R13 R14
            PRX_ADDR_TRIM:   rd_mux = crosstalk_trim;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cr_ack_tgl     <= 1'b0;
            cr_rdata       <= 8'h00;
            analog_setup   <= PRX_SETUP_RST;
            crosstalk_trim <= PRX_TRIM_RST; // R18
            result_shadow  <= 8'h00;
        end
        else
        begin
            if (cr_req_seen)
            begin
                cr_ack_tgl <= ~cr_ack_tgl;
            end
            if (cr_wr && hit_setup)
            begin
                analog_setup <= req_bits_setup(lk_wdata);
            end
            if (cr_wr && hit_trim)
            begin
                crosstalk_trim <= lk_wdata;
            end
            if (cr_rd)
            begin
                cr_rdata <= rd_mux;
            end
            // Snapshot keeps the byte pair coherent across later conversions
            if (cr_rd && hit_res_lo)
            begin
                result_shadow <= prox_result[15:8]; // R13 R14
            end
        end
    end

    // Reserved low bits of the setup register are kept at zero
    function automatic logic [7:0] req_bits_setup(input logic [7:0] wdata);
        return {wdata[7:2], 2'h0};
    endfunction

    // Analog setup decode
    wire logic [1:0] drive_code = analog_setup[PRX_DRIVE_MSB:PRX_DRIVE_LSB];
    wire logic [1:0] diode_code = analog_setup[PRX_DIODE_MSB:PRX_DIODE_LSB];
    wire logic [1:0] gain_code  = analog_setup[PRX_GAIN_MSB:PRX_GAIN_LSB];
    wire logic [3:0] gain_mult  = 4'h1 << gain_code; // R5
    wire logic [3:0] drive_wt   = 4'h8 >> drive_code;

    assign led_current_select_out = drive_code; // R1
    assign led_current_reduce_out = led_current_reduce_in; // R2
    assign led_current_ma10_out   = prx_led_ma10(drive_code, led_current_reduce_in); // R1 R2
    // Code 11 is never written by the host; it safely selects no diode
    assign broadband_diode_en_out = (diode_code == PRX_DIODE_BROAD); // R3 R4
    assign infrared_diode_en_out  = (diode_code == PRX_DIODE_IR); // R3
    assign prox_amp_gain_out      = gain_mult; // R5
    assign prox_measure_run_out   = prox_function_on_in; // R20

    // Open-drain interrupt, driven low only while pending and unmasked
    assign irq_pin_out    = 1'b0;
    assign irq_pin_oe_out = prox_irq_pending_in && prox_irq_unmask_in; // R21

    // Offset trim; the reduced drive column is not folded into the weight
    // Operands widened first so the product cannot wrap; the peak value needs 21 bits
    wire logic [22:0] trim_mag   = {16'h0000, crosstalk_trim[6:0]};
    wire logic [22:0] trim_gain  = {19'h00000, gain_mult};
    wire logic [22:0] trim_drive = {19'h00000, drive_wt};
    wire logic [22:0] trim_pulse = {15'h0000, led_pulse_count_in};
    wire logic [22:0] trim_shift = trim_mag * trim_gain * trim_drive * trim_pulse; // R17
    wire logic [23:0] raw_ext    = {8'h00, conv_data_in};
    wire logic [23:0] shift_ext  = {1'b0, trim_shift};
    wire logic [23:0] sum_up     = raw_ext + shift_ext;
    wire logic [15:0] trim_up    = (sum_up > 24'h00ffff) ? 16'hffff : sum_up[15:0];
    wire logic [23:0] sum_dn     = raw_ext - shift_ext;
    wire logic [15:0] trim_dn    = (shift_ext > raw_ext) ? 16'h0000 : sum_dn[15:0];
    wire logic [15:0] next_result = crosstalk_trim[PRX_SIGN_BIT] ? trim_up : trim_dn; // R16
    wire logic        cycle_end   = conv_done_in && prox_function_on_in; // R20

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prox_result        <= 16'h0000;
            prox_overload_flag <= PRX_FLAGS_RST[PRX_FLAG_SAT];
            prox_result_ready  <= PRX_FLAGS_RST[PRX_FLAG_RDY];
        end
        else
        begin
            if (cycle_end)
            begin
                prox_result        <= next_result; // R22
                prox_overload_flag <= conv_overload_in; // R9 R22
            end
            // Ready drops with the enable and sets again after the next full cycle
            if (!prox_function_on_in)
            begin
                prox_result_ready <= 1'b0;
            end
            else if (cycle_end)
            begin
                prox_result_ready <= 1'b1; // R11 R22
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/prx_host_model.sv */
// Host-side register link driver standing in for the bus controller
`timescale 1ns/100ps
`default_nettype none
module prx_host_model
(
    input  wire logic       bus_clk_in,
    input  wire logic       req_ready_in,
    input  wire logic       rsp_valid_in,
    input  wire logic [7:0] rsp_rdata_in,
    output var logic        req_valid_out = 1'b0,
    output var logic        req_write_out = 1'b0,
    output var logic [7:0]  req_addr_out = 8'h00,
    output var logic [7:0]  req_wdata_out = 8'h00
);
    // One request at a time; address and data lines are inverted on release so stale values never pass
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        q = 8'hxx;
        @(posedge bus_clk_in);
        req_valid_out <= 1'b1;
        req_write_out <= w;
        req_addr_out <= a;
        req_wdata_out <= d;
        do @(posedge bus_clk_in); while (!req_ready_in && ++n < 40);
        req_valid_out <= 1'b0;
        req_addr_out <= ~a;
        req_wdata_out <= ~d;
        do @(posedge bus_clk_in); while (!rsp_valid_in && ++n < 40);
        if (n < 40)
            q = rsp_rdata_in;
    endtask
endmodule
`default_nettype wire

/* testbench/prx_readout_asserts.sv */
// Port assertions for the proximity readout block
`timescale 1ns/100ps
`default_nettype none
module prx_readout_asserts
(
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic        bus_clk_in,
    input wire logic        req_valid_in,
    input wire logic        req_ready_out,
    input wire logic        rsp_valid_out,
    input wire logic        prox_function_on_in,
    input wire logic        prox_irq_unmask_in,
    input wire logic        prox_irq_pending_in,
    input wire logic        led_current_reduce_in,
    input wire logic        prox_measure_run_out,
    input wire logic [1:0]  led_current_select_out,
    input wire logic        led_current_reduce_out,
    input wire logic [10:0] led_current_ma10_out,
    input wire logic        broadband_diode_en_out,
    input wire logic        infrared_diode_en_out,
    input wire logic [3:0]  prox_amp_gain_out,
    input wire logic        irq_pin_out,
    input wire logic        irq_pin_oe_out
);
    // Reduced column is rounded, not a plain shift, hence a table
    localparam logic [10:0] RED_MA [4] = '{11'h096, 11'h04b, 11'h026, 11'h013};
    wire logic [10:0] exp_ma;
    assign exp_ma = led_current_reduce_out ? RED_MA[led_current_select_out] : 11'h4b0 >> led_current_select_out;

    run_follow_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        prox_measure_run_out == prox_function_on_in) else $error("run differs");
    irq_mask_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        irq_pin_oe_out == (prox_irq_pending_in && prox_irq_unmask_in) && !irq_pin_out) else $error("irq pin");
    drive_cur_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        led_current_ma10_out == exp_ma) else $error("led current");
    reduce_pass_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        led_current_reduce_out == led_current_reduce_in) else $error("reduce");
    diode_excl_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !(broadband_diode_en_out && infrared_diode_en_out)) else $error("two diodes");
    gain_onehot_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $onehot(prox_amp_gain_out)) else $error("gain");
    take_busy_a: assert property (@(posedge bus_clk_in) disable iff (!rst_b_in)
        req_valid_in && req_ready_out |=> !req_ready_out [*3]) else $error("ready early");
    rsp_bound_a: assert property (@(posedge bus_clk_in) disable iff (!rst_b_in)
        req_valid_in && req_ready_out |-> ##[2:20] rsp_valid_out) else $error("no response");
    rsp_pulse_a: assert property (@(posedge bus_clk_in) disable iff (!rst_b_in)
        rsp_valid_out |-> req_ready_out ##1 !rsp_valid_out) else $error("response pulse");

    cover property (@(posedge mclk_in) irq_pin_oe_out);
    cover property (@(posedge bus_clk_in) rsp_valid_out);
    cover property (@(posedge mclk_in) led_current_reduce_out && led_current_select_out == 2'h3);
endmodule
bind prx_readout prx_readout_asserts u_chk (.*);
`default_nettype wire

/* testbench/prx_readout_tb_top.sv */
// Self-checking bench for the proximity readout block
`timescale 1ns/100ps
`default_nettype none
module prx_readout_tb_top;
    import prx_pkg::*;
    logic mclk_in = 1'b0, bus_clk_in = 1'b0, rst_b_in = 1'b0;
    logic prox_function_on_in = 1'b0, prox_irq_unmask_in = 1'b0, led_current_reduce_in = 1'b0;
    logic conv_done_in = 1'b0, conv_overload_in = 1'b0, prox_irq_pending_in = 1'b0;
    logic [7:0] led_pulse_count_in = 8'h01;
    logic [15:0] conv_data_in = 16'h0000;
    logic req_valid_in, req_write_in, req_ready_out, rsp_valid_out, prox_measure_run_out;
    logic led_current_reduce_out, broadband_diode_en_out, infrared_diode_en_out, irq_pin_out, irq_pin_oe_out;
    logic [7:0] req_addr_in, req_wdata_in, rsp_rdata_out, q, setup_m, trim_m;
    logic [1:0] led_current_select_out;
    logic [10:0] led_current_ma10_out;
    logic [3:0] prox_amp_gain_out;
    logic [10:0] red_ma [4] = '{11'h096, 11'h04b, 11'h026, 11'h013};
    logic [31:0] lfsr_s = 32'h5921c661;
    logic ovl_m = 1'b0, rdy_m = 1'b0;
    int failures = 0, checks = 0, res_m, shadow_m;

    always #10 mclk_in = ~mclk_in;
    always #3 bus_clk_in = ~bus_clk_in;

    prx_host_model host (.bus_clk_in(bus_clk_in), .req_ready_in(req_ready_out), .rsp_valid_in(rsp_valid_out),
        .rsp_rdata_in(rsp_rdata_out), .req_valid_out(req_valid_in), .req_write_out(req_write_in),
        .req_addr_out(req_addr_in), .req_wdata_out(req_wdata_in));
    prx_readout uut (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int exp_res(input int d);
        int sh;
        sh = trim_m[6:0] * (1 << setup_m[3:2]) * (8 >> setup_m[7:6]) * led_pulse_count_in;
        if (trim_m[7])
            return (d + sh > 65535) ? 65535 : d + sh;
        return (d < sh) ? 0 : d - sh;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q);
        // A write that never answers leaves the data unknown
        if ($isunknown(q))
            failures++;
    endtask
    task automatic conv(input logic o);
        lfsr_s = lfsr(lfsr_s);
        @(posedge mclk_in);
        conv_done_in <= 1'b1;
        conv_data_in <= lfsr_s[15:0];
        conv_overload_in <= o;
        if (prox_function_on_in)
        begin
            res_m = exp_res(lfsr_s[15:0]);
            ovl_m = o;
            rdy_m = 1'b1;
        end
        @(posedge mclk_in);
        conv_done_in <= 1'b0;
        conv_data_in <= ~lfsr_s[15:0];
        repeat (2) @(posedge mclk_in);
    endtask
    task automatic end_of_test;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        failures++;
        end_of_test;
    end

    initial
    begin
        repeat (12) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rdc(PRX_ADDR_SETUP, PRX_SETUP_RST);
        rdc(PRX_ADDR_TRIM, PRX_TRIM_RST);
        rdc(PRX_ADDR_FLAGS, PRX_FLAGS_RST);
        wr(PRX_ADDR_IDENT, 8'hff);
        wr(PRX_ADDR_FLAGS, 8'hff);
        rdc(PRX_ADDR_IDENT, PRX_IDENT_DFLT);
        rdc(PRX_ADDR_FLAGS, 8'h00);
        rdc(8'h40, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            setup_m = {i[1:0], (i == 3) ? 2'h0 : i[1:0], i[1:0], 2'h0};
            wr(PRX_ADDR_SETUP, setup_m | 8'h03);
            rdc(PRX_ADDR_SETUP, setup_m);
            for (int r = 0; r < 2; r++)
            begin
                @(posedge mclk_in);
                led_current_reduce_in <= r[0];
                repeat (2) @(posedge mclk_in);
                chk(led_current_ma10_out, r[0] ? red_ma[i] : 11'h4b0 >> i);
            end
            chk({prox_amp_gain_out, led_current_select_out}, {4'h1 << i, i[1:0]});
            chk({broadband_diode_en_out, infrared_diode_en_out}, {i == 1, i == 2});
        end
        setup_m = 8'h18;
        wr(PRX_ADDR_SETUP, setup_m);
        @(posedge mclk_in);
        prox_function_on_in <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            lfsr_s = lfsr(lfsr_s);
            trim_m = lfsr_s[23:16];
            @(posedge mclk_in);
            led_pulse_count_in <= {6'h00, lfsr_s[25:24]} + 8'h01;
            prox_irq_pending_in <= k[0];
            prox_irq_unmask_in <= k[1];
            wr(PRX_ADDR_TRIM, trim_m);
            rdc(PRX_ADDR_TRIM, trim_m);
            conv(lfsr_s[26]);
            rdc(PRX_ADDR_FLAGS, {1'b0, ovl_m, k[0], 3'h0, rdy_m, 1'b0});
            rdc(PRX_ADDR_RES_LO, res_m[7:0]);
            shadow_m = res_m;
            conv(1'b0);
            rdc(PRX_ADDR_RES_HI, shadow_m[15:8]);
        end
        @(posedge mclk_in);
        prox_function_on_in <= 1'b0;
        prox_irq_pending_in <= 1'b0;
        rdy_m = 1'b0;
        conv(1'b1);
        rdc(PRX_ADDR_FLAGS, {1'b0, ovl_m, 6'h00});
        rdc(PRX_ADDR_RES_LO, res_m[7:0]);
        end_of_test;
    end
endmodule
`default_nettype wire
